/* File: logic/otce_consts.svh */
// Constants of the overcurrent time element: offsets, fields, reset values, timing
`ifndef OTCE_CONSTS_SVH
`define OTCE_CONSTS_SVH

// ------------------------------------------------------------
// Timing
// ------------------------------------------------------------
`define OTCE_CLK_MHZ 50
`define OTCE_SAMPLE_US 1000
`define OTCE_SAMPLE_DMS 10
`define OTCE_ACC_FRAC 20
`define OTCE_ACC_FULL 21'h10_0000

// ------------------------------------------------------------
// Fixed point and curve constants (delays in 0.1 ms units)
// ------------------------------------------------------------
`define OTCE_ONE 32'h0000_1000
`define OTCE_MAX_RATIO 32'h0002_8000
`define OTCE_LN_SCALE 32'h0000_00E3
`define OTCE_IEC_VI_B 32'h0002_0F58
`define OTCE_IEC_LTI_B 32'h0012_4F80
`define OTCE_IEEE_MI_A 32'h0000_0474
`define OTCE_IEEE_MI_B 32'h0000_0203
`define OTCE_IEEE_EI_A 32'h0000_04C1
`define OTCE_IEEE_EI_B 32'h0004_4D90
`define OTCE_US_EI_A 32'h0000_0160
`define OTCE_US_EI_B 32'h0000_DD7C
`define OTCE_TR_IEC_VI 32'h0006_9780
`define OTCE_TR_IEC_LTI 32'h000C_3500
`define OTCE_TR_IEEE_MI 32'h0000_BD74
`define OTCE_TR_IEEE_EI 32'h0004_70B8
`define OTCE_TR_US_EI 32'h0000_DD7C

// ------------------------------------------------------------
// Percentages and multiplier limits (multiplier in hundredths)
// ------------------------------------------------------------
`define OTCE_PCT_FULL 32'h0000_0064
`define OTCE_PCT_KEEP 32'h0000_005A
`define OTCE_PCT_FLOOR 32'h0000_0019
`define OTCE_PCT_PICK 32'h0000_0069
`define OTCE_MULT_IEC_MAX 10'h064
`define OTCE_MULT_OTHER_MIN 10'h00A

// ------------------------------------------------------------
// Register map
// ------------------------------------------------------------
`define OTCE_REG_VD_CTRL 8'h00
`define OTCE_REG_NOMINAL 8'h04
`define OTCE_REG_OPERATE 8'h08
`define OTCE_REG_STATUS 8'h0C
`define OTCE_ELEM_BASE 8'h40
`define OTCE_ELEM_END 8'hA0
`define OTCE_ELEM_PICKUP 4'h0
`define OTCE_ELEM_CONFIG 4'h4
`define OTCE_ELEM_MULT 4'h8
`define OTCE_ELEM_DEFINITE 4'hC

// Config fields: enable, curve, direction, ground unit select, reset type
`define OTCE_CFG_EN 0
`define OTCE_CFG_CURVE_LO 1
`define OTCE_CFG_DIR_LO 4
`define OTCE_CFG_DIR_SEL 6
`define OTCE_CFG_DISC 7
`define OTCE_VD_ROT_ACB 2

// Reset values
`define OTCE_RST_MULT 10'h064
`define OTCE_RST_DEFINITE 24'h00_01F4
`define OTCE_RST_NOMINAL 16'h0064
`endif

/* File: logic/otce_pkg.sv */
// Types of the overcurrent time element
package otce_pkg;

  typedef enum logic [2:0] {
    CURVE_DEFINITE,
    CURVE_IEC_VI,
    CURVE_IEC_LTI,
    CURVE_IEEE_MI,
    CURVE_IEEE_EI,
    CURVE_US_EI,
    CURVE_RI
  } otce_curve_t;

  typedef enum logic [1:0] {DIR_NONE, DIR_FWD, DIR_REV} otce_dir_t;

  typedef enum logic [1:0] {VD_OFF, VD_RESTRAINT, VD_CONTROLLED} otce_vd_mode_t;

  typedef struct packed {
    logic [15:0] tick_cnt;
    logic tick;
    logic [2:0] vd_ctrl;
    logic [15:0] nominal;
    logic [15:0] operate;
    logic [5:0][15:0] pickup_set;
    logic [5:0][7:0] elem_cfg;
    logic [5:0][9:0] mult;
    logic [5:0][23:0] definite;
    logic [5:0][20:0] acc;
    logic [5:0] picked;
    logic [5:0] trip;
    logic [2:0] uv;
    logic [31:0] rdata;
  } otce_state_t;

endpackage

/* File: logic/otce_top.sv */
// Time-delayed overcurrent element: six elements, curves, voltage dependence, supervision
//
// Operation
// - IEC very inverse: 13.5/(Is-1) times multiplier
// - IEC long-time inverse: 120/(Is-1) times multiplier
// - IEEE moderately inverse curve with 0.02 exponent
// - IEEE extremely inverse: 0.1217 + 28.2/(Is^2-1)
// - US extremely inverse: 0.0352 + 5.67/(Is^2-1)
// - Negative sequence reuses same timing and curves
// - Voltage restraint or voltage controlled pickup modes
// - Phase control voltage chosen by phase rotation
// - Restraint pickup full above 90%, tracks below
// - Restraint pickup clamped at 25% below 25%
// - Voltage percent taken against nominal setting
// - Controlled mode: pickup only below operate voltage
// - Current picks at 105%, drops at 100%
// - Undervoltage enable at 100%, release at 105%
// - Directional supervision: none, forward or reverse
// - No supervision ignores direction inputs
// - Direction flags come from external directional units
// - Phase and negative sequence use fixed units
// - Inhibit before trip prevents the trip
// - Inhibit after trip resets the trip
// - Delay bypass trips at once on pickup
// - Instantaneous reset clears integrator on dropout
// - Disc emulation decrements along reset curve
// - IEC multiplier limited to one
// - RI curve always resets instantaneously
//
// Local design decisions: strobed register access and the register addresses.
`include "otce_consts.svh"

module otce_top #(
  parameter int SAMPLE_CYCLES = `OTCE_SAMPLE_US * `OTCE_CLK_MHZ
) (
  input wire logic clk,
  input wire logic reset,
  input wire logic [7:0] addr,
  input wire logic [31:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [31:0] rdata,
  input wire logic [15:0] phase_a_current,
  input wire logic [15:0] phase_b_current,
  input wire logic [15:0] phase_c_current,
  input wire logic [15:0] ground_current,
  input wire logic [15:0] sens_ground_current,
  input wire logic [15:0] negseq_current,
  input wire logic [15:0] voltage_a_to_b,
  input wire logic [15:0] voltage_b_to_c,
  input wire logic [15:0] voltage_c_to_a,
  input wire logic [15:0] voltage_a_to_c,
  input wire logic [15:0] voltage_b_to_a,
  input wire logic [15:0] voltage_c_to_b,
  input wire logic [2:0] phase_directional_unit_fwd,
  input wire logic [2:0] phase_directional_unit_rev,
  input wire logic ground_directional_unit_fwd,
  input wire logic ground_directional_unit_rev,
  input wire logic negseq_directional_unit_fwd,
  input wire logic negseq_directional_unit_rev,
  input wire logic [5:0] trip_inhibit,
  input wire logic [5:0] delay_bypass,
  output logic [5:0] trip,
  output logic [5:0] pickup
);

  otce_pkg::otce_state_t s;
  otce_pkg::otce_state_t next_s;

  logic [5:0][15:0] cur_in;
  logic [2:0][15:0] vctl;
  logic [2:0][31:0] pct;
  logic [5:0][31:0] pu_eff;
  logic [5:0] dfwd;
  logic [5:0] drev;
  logic [1:0] vd_mode;

  // ------------------------------------------------------------
  // Curve arithmetic
  // ------------------------------------------------------------
  // Piecewise-linear log2, Q12 in and out; input is at least one
  function automatic logic [31:0] log2_q12(input logic [31:0] r);
    logic [4:0] p;
    logic [31:0] norm;
    p = 5'h0;
    for (int k = 0; k < 32; k++) begin
      if (r[k]) begin
        p = 5'(k);
      end
    end
    norm = r << (5'h1F - p);
    return ((32'(p) - 32'h0000_000C) << 12) | {20'h0_0000, norm[30:19]};
  endfunction

  function automatic logic [9:0] eff_mult(input logic [2:0] curve, input logic [9:0] tm);
    logic [9:0] m;
    m = tm;
    if (curve == otce_pkg::CURVE_IEC_VI || curve == otce_pkg::CURVE_IEC_LTI) begin
      if (tm > `OTCE_MULT_IEC_MAX) begin
        m = `OTCE_MULT_IEC_MAX;
      end
    end else if (tm < `OTCE_MULT_OTHER_MIN) begin
      m = `OTCE_MULT_OTHER_MIN;
    end
    return m;
  endfunction

  // Trip delay in 0.1 ms for ratio r (Q12); denominators are held in Q16
  function automatic logic [31:0] curve_dms(input logic [2:0] curve, input logic [31:0] r,
                                            input logic [9:0] tm, input logic [23:0] defin);
    logic [63:0] a;
    logic [63:0] b;
    logic [63:0] den;
    logic [63:0] rr;
    logic [63:0] t;
    a = 64'h0;
    b = 64'h0;
    rr = 64'(r);
    den = (rr - 64'(`OTCE_ONE)) << 4;
    case (curve)
      otce_pkg::CURVE_IEC_VI: begin
        b = 64'(`OTCE_IEC_VI_B);
      end
      otce_pkg::CURVE_IEC_LTI: begin
        b = 64'(`OTCE_IEC_LTI_B);
      end
      otce_pkg::CURVE_IEEE_MI: begin
        // Is^0.02 - 1 taken as 0.02 ln Is; error stays small over the curve range
        a = 64'(`OTCE_IEEE_MI_A);
        b = 64'(`OTCE_IEEE_MI_B);
        den = (64'(log2_q12(r)) * 64'(`OTCE_LN_SCALE)) >> 10;
      end
      otce_pkg::CURVE_IEEE_EI: begin
        a = 64'(`OTCE_IEEE_EI_A);
        b = 64'(`OTCE_IEEE_EI_B);
        den = ((rr * rr) >> 8) - 64'h1_0000;
      end
      otce_pkg::CURVE_US_EI: begin
        a = 64'(`OTCE_US_EI_A);
        b = 64'(`OTCE_US_EI_B);
        den = ((rr * rr) >> 8) - 64'h1_0000;
      end
      default: begin
      end
    endcase
    if (den == 64'h0) begin
      den = 64'h1;
    end
    if (curve == otce_pkg::CURVE_DEFINITE || curve == otce_pkg::CURVE_RI) begin
      t = 64'(defin);
    end else begin
      t = ((a + (b << 16) / den) * 64'(eff_mult(curve, tm))) / 64'(`OTCE_PCT_FULL);
    end
    if (t == 64'h0) begin
      t = 64'h1;
    end
    if (t > 64'hFFFF_FFFF) begin
      t = 64'hFFFF_FFFF;
    end
    return t[31:0];
  endfunction

  function automatic logic [31:0] reset_dms(input logic [2:0] curve, input logic [9:0] tm);
    logic [63:0] tr;
    case (curve)
      otce_pkg::CURVE_IEC_VI: tr = 64'(`OTCE_TR_IEC_VI);
      otce_pkg::CURVE_IEC_LTI: tr = 64'(`OTCE_TR_IEC_LTI);
      otce_pkg::CURVE_IEEE_MI: tr = 64'(`OTCE_TR_IEEE_MI);
      otce_pkg::CURVE_IEEE_EI: tr = 64'(`OTCE_TR_IEEE_EI);
      otce_pkg::CURVE_US_EI: tr = 64'(`OTCE_TR_US_EI);
      default: tr = 64'h1;
    endcase
    tr = (tr * 64'(eff_mult(curve, tm))) / 64'(`OTCE_PCT_FULL);
    if (tr == 64'h0) begin
      tr = 64'h1;
    end
    return tr[31:0];
  endfunction

  // ------------------------------------------------------------
  // Inputs, supervision and effective pickup
  // ------------------------------------------------------------
  always_comb begin
    logic [63:0] p;
    p = 64'h0;
    vd_mode = s.vd_ctrl[1:0];
    // Element order: phase A, B, C, ground, sensitive ground, negative sequence
    cur_in = {negseq_current, sens_ground_current, ground_current,
              phase_c_current, phase_b_current, phase_a_current};
    if (s.vd_ctrl[`OTCE_VD_ROT_ACB]) begin
      vctl = {voltage_c_to_b, voltage_b_to_a, voltage_a_to_c};
    end else begin
      vctl = {voltage_c_to_a, voltage_b_to_c, voltage_a_to_b};
    end
    // Direction flags are taken as given by the directional units
    dfwd[2:0] = phase_directional_unit_fwd;
    drev[2:0] = phase_directional_unit_rev;
    dfwd[5] = negseq_directional_unit_fwd;
    drev[5] = negseq_directional_unit_rev;
    for (int i = 3; i < 5; i++) begin
      if (s.elem_cfg[i][`OTCE_CFG_DIR_SEL]) begin
        dfwd[i] = negseq_directional_unit_fwd;
        drev[i] = negseq_directional_unit_rev;
      end else begin
        dfwd[i] = ground_directional_unit_fwd;
        drev[i] = ground_directional_unit_rev;
      end
    end
    for (int i = 0; i < 6; i++) begin
      pu_eff[i] = 32'(s.pickup_set[i]);
    end
    for (int i = 0; i < 3; i++) begin
      if (s.nominal == 16'h0000) begin
        pct[i] = `OTCE_PCT_FULL;
      end else begin
        p = (64'(vctl[i]) * 64'(`OTCE_PCT_FULL)) / 64'(s.nominal);
        pct[i] = 32'(p);
      end
      if (vd_mode == otce_pkg::VD_RESTRAINT) begin
        if (pct[i] >= `OTCE_PCT_KEEP) begin
          pu_eff[i] = 32'(s.pickup_set[i]);
        end else if (pct[i] < `OTCE_PCT_FLOOR) begin
          pu_eff[i] = 32'(s.pickup_set[i]) * `OTCE_PCT_FLOOR / `OTCE_PCT_FULL;
        end else begin
          pu_eff[i] = 32'(s.pickup_set[i]) * pct[i] / `OTCE_PCT_FULL;
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Next state: register port, sample divider, elements
  // ------------------------------------------------------------
  always_comb begin
    logic [7:0] off;
    logic [2:0] idx;
    logic [2:0] curve;
    logic [9:0] tme;
    logic [63:0] cur;
    logic [63:0] pu;
    logic [63:0] r;
    logic [63:0] inc;
    logic [63:0] dec;
    logic [63:0] acc;
    logic [63:0] v;
    logic allow;
    logic dir_ok;
    logic inst;
    off = addr - `OTCE_ELEM_BASE;
    idx = off[6:4];
    curve = 3'h0;
    tme = 10'h000;
    cur = 64'h0;
    pu = 64'h0;
    r = 64'h0;
    inc = 64'h0;
    dec = 64'h0;
    acc = 64'h0;
    v = 64'h0;
    allow = 1'b1;
    dir_ok = 1'b1;
    inst = 1'b1;
    next_s = s;

    // One-cycle sample enable from the divider
    next_s.tick = 1'b0;
    if (s.tick_cnt >= 16'(SAMPLE_CYCLES - 1)) begin
      next_s.tick_cnt = 16'h0000;
      next_s.tick = 1'b1;
    end else begin
      next_s.tick_cnt = s.tick_cnt + 16'h0001;
    end

    if (wr_en) begin
      if (addr == `OTCE_REG_VD_CTRL) begin
        next_s.vd_ctrl = wdata[2:0];
      end else if (addr == `OTCE_REG_NOMINAL) begin
        next_s.nominal = wdata[15:0];
      end else if (addr == `OTCE_REG_OPERATE) begin
        next_s.operate = wdata[15:0];
      end else if (addr >= `OTCE_ELEM_BASE && addr < `OTCE_ELEM_END) begin
        case (addr[3:0])
          `OTCE_ELEM_PICKUP: next_s.pickup_set[idx] = wdata[15:0];
          `OTCE_ELEM_CONFIG: next_s.elem_cfg[idx] = wdata[7:0];
          `OTCE_ELEM_MULT: next_s.mult[idx] = wdata[9:0];
          `OTCE_ELEM_DEFINITE: next_s.definite[idx] = wdata[23:0];
          default: begin
          end
        endcase
      end
    end

    next_s.rdata = 32'h0000_0000;
    if (rd_en) begin
      if (addr == `OTCE_REG_VD_CTRL) begin
        next_s.rdata = {29'h0000_0000, s.vd_ctrl};
      end else if (addr == `OTCE_REG_NOMINAL) begin
        next_s.rdata = {16'h0000, s.nominal};
      end else if (addr == `OTCE_REG_OPERATE) begin
        next_s.rdata = {16'h0000, s.operate};
      end else if (addr == `OTCE_REG_STATUS) begin
        next_s.rdata = {13'h0000, s.uv, 2'h0, s.trip, 2'h0, s.picked};
      end else if (addr >= `OTCE_ELEM_BASE && addr < `OTCE_ELEM_END) begin
        case (addr[3:0])
          `OTCE_ELEM_PICKUP: next_s.rdata = {16'h0000, s.pickup_set[idx]};
          `OTCE_ELEM_CONFIG: next_s.rdata = {24'h00_0000, s.elem_cfg[idx]};
          `OTCE_ELEM_MULT: next_s.rdata = {22'h00_0000, s.mult[idx]};
          `OTCE_ELEM_DEFINITE: next_s.rdata = {8'h00, s.definite[idx]};
          default: next_s.rdata = 32'h0000_0000;
        endcase
      end
    end

    for (int i = 0; i < 3; i++) begin
      v = 64'(vctl[i]) * 64'(`OTCE_PCT_FULL);
      if (s.uv[i]) begin
        next_s.uv[i] = !(v >= 64'(s.operate) * 64'(`OTCE_PCT_PICK));
      end else begin
        next_s.uv[i] = vctl[i] <= s.operate;
      end
    end

    for (int i = 0; i < 6; i++) begin
      curve = s.elem_cfg[i][`OTCE_CFG_CURVE_LO +: 3];
      tme = s.mult[i];
      cur = 64'(cur_in[i]);
      pu = 64'(pu_eff[i]);
      allow = 1'b1;
      if (i < 3 && vd_mode == otce_pkg::VD_CONTROLLED) begin
        allow = s.uv[i];
      end
      case (s.elem_cfg[i][`OTCE_CFG_DIR_LO +: 2])
        otce_pkg::DIR_FWD: dir_ok = dfwd[i];
        otce_pkg::DIR_REV: dir_ok = drev[i];
        default: dir_ok = 1'b1;
      endcase
      if (s.picked[i]) begin
        next_s.picked[i] = cur > pu;
      end else begin
        next_s.picked[i] = cur * 64'(`OTCE_PCT_FULL) >= pu * 64'(`OTCE_PCT_PICK);
      end
      next_s.picked[i] = next_s.picked[i] && s.elem_cfg[i][`OTCE_CFG_EN] && allow
                         && dir_ok && pu != 64'h0;

      // Above forty times pickup the delay is held at the forty-times value
      r = (pu == 64'h0) ? 64'(`OTCE_MAX_RATIO) : (cur << 12) / pu;
      if (r > 64'(`OTCE_MAX_RATIO)) begin
        r = 64'(`OTCE_MAX_RATIO);
      end
      inc = (64'(`OTCE_SAMPLE_DMS) << `OTCE_ACC_FRAC)
            / 64'(curve_dms(curve, 32'(r), tme, s.definite[i]));
      dec = (64'(`OTCE_SAMPLE_DMS) << `OTCE_ACC_FRAC) / 64'(reset_dms(curve, tme));
      inst = !s.elem_cfg[i][`OTCE_CFG_DISC] || curve == otce_pkg::CURVE_RI
             || curve == otce_pkg::CURVE_DEFINITE;
      acc = 64'(s.acc[i]);
      if (!s.picked[i] && inst) begin
        acc = 64'h0;
      end else if (s.tick && s.picked[i]) begin
        acc = acc + inc;
        if (acc > 64'(`OTCE_ACC_FULL)) begin
          acc = 64'(`OTCE_ACC_FULL);
        end
      end else if (s.tick) begin
        acc = (acc > dec) ? acc - dec : 64'h0;
      end
      next_s.acc[i] = 21'(acc);

      next_s.trip[i] = !trip_inhibit[i] && s.picked[i]
                       && (s.trip[i] || delay_bypass[i]
                           || s.acc[i] >= `OTCE_ACC_FULL);
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      s <= '0;
      s.mult <= {6{`OTCE_RST_MULT}};
      s.definite <= {6{`OTCE_RST_DEFINITE}};
      s.nominal <= `OTCE_RST_NOMINAL;
    end else begin
      s <= next_s;
    end
  end

  assign rdata = s.rdata;
  assign trip = s.trip;
  assign pickup = s.picked;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (reset);

  inhibit_resets_trip_a: assert property (
    s.trip[0] && trip_inhibit[0] ##1 trip_inhibit[0] |-> !trip[0] [*2])
    else $error("Trip stayed after inhibit");

  inhibit_blocks_trip_a: assert property (
    !s.trip[0] && trip_inhibit[0] |=> !trip[0])
    else $error("Trip issued while inhibited");

  bypass_trips_a: assert property (
    s.picked[0] && delay_bypass[0] && !trip_inhibit[0] |=> trip[0])
    else $error("Bypass did not trip on pickup");

  integrator_full_a: assert property (
    s.picked[4] && s.acc[4] >= `OTCE_ACC_FULL && !trip_inhibit[4] |=> trip[4])
    else $error("Full integrator did not trip");

  inst_reset_clear_a: assert property (
    !s.picked[5] && !s.elem_cfg[5][`OTCE_CFG_DISC] |=> s.acc[5] == 21'h00_0000)
    else $error("Integrator not cleared on dropout");

  restraint_full_a: assert property (
    vd_mode == otce_pkg::VD_RESTRAINT && pct[1] >= `OTCE_PCT_KEEP
    |-> pu_eff[1] == 32'(s.pickup_set[1]))
    else $error("Restraint pickup not at full setting");

  restraint_floor_a: assert property (
    vd_mode == otce_pkg::VD_RESTRAINT && pct[0] < `OTCE_PCT_FLOOR
    |-> pu_eff[0] == 32'(s.pickup_set[0]) * `OTCE_PCT_FLOOR / `OTCE_PCT_FULL)
    else $error("Restraint pickup not clamped");

  undervolt_set_a: assert property (
    !s.uv[0] && vctl[0] <= s.operate ##1 vctl[0] <= s.operate |-> s.uv[0])
    else $error("Undervoltage enable missed");

  controlled_block_a: assert property (
    vd_mode == otce_pkg::VD_CONTROLLED && !s.uv[1] |=> !pickup[1])
    else $error("Pickup without undervoltage");

  forward_block_a: assert property (
    s.elem_cfg[0][`OTCE_CFG_DIR_LO +: 2] == otce_pkg::DIR_FWD
    && !phase_directional_unit_fwd[0] |=> !pickup[0])
    else $error("Pickup against direction");

endmodule

/* File: testbench/otce_front.sv */
// Measurement front end and directional units feeding the element
module otce_front;
  timeunit 1ns;
  timeprecision 1ns;
  logic [5:0][15:0] cur = '0;
  logic [5:0][15:0] volt = {6{16'h03E8}};
  // Bits 2:0 phase units, 3 ground unit, 4 negseq unit; made outside the element
  logic [4:0] fwd = 5'h00;
  logic [4:0] rev = 5'h00;
endmodule

/* File: testbench/tb_top.sv */
// Self-checking bench of the overcurrent time element
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  // Short tick: integration still counts each tick as 1 ms
  localparam int SC = 50;
  logic clk = 1'b0, reset = 1'b1, wr_en = 1'b0, rd_en = 1'b0;
  logic [7:0] addr = 8'h00;
  logic [31:0] wdata = 32'h0000_0000;
  logic [31:0] rdata;
  logic [5:0] trip_inhibit = 6'h00, delay_bypass = 6'h00, trip, pickup;
  int error_cnt = 0, comparisons = 0, cyc = 0;
  otce_front fe();
  otce_top #(.SAMPLE_CYCLES(SC)) uut (
    .clk(clk), .reset(reset), .addr(addr), .wdata(wdata), .wr_en(wr_en), .rd_en(rd_en),
    .rdata(rdata), .phase_a_current(fe.cur[0]), .phase_b_current(fe.cur[1]),
    .phase_c_current(fe.cur[2]), .ground_current(fe.cur[3]),
    .sens_ground_current(fe.cur[4]), .negseq_current(fe.cur[5]),
    .voltage_a_to_b(fe.volt[0]), .voltage_b_to_c(fe.volt[1]), .voltage_c_to_a(fe.volt[2]),
    .voltage_a_to_c(fe.volt[3]), .voltage_b_to_a(fe.volt[4]), .voltage_c_to_b(fe.volt[5]),
    .phase_directional_unit_fwd(fe.fwd[2:0]), .phase_directional_unit_rev(fe.rev[2:0]),
    .ground_directional_unit_fwd(fe.fwd[3]), .ground_directional_unit_rev(fe.rev[3]),
    .negseq_directional_unit_fwd(fe.fwd[4]), .negseq_directional_unit_rev(fe.rev[4]),
    .trip_inhibit(trip_inhibit), .delay_bypass(delay_bypass), .trip(trip), .pickup(pickup)
  );
  always #10 clk = ~clk;
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 80000) begin
      error_cnt++;
      conclude();
    end
  end
  task automatic conclude();
    $display("Mismatches %0d, comparisons %0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    @(posedge clk);
    wr_en <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    @(posedge clk);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk);
    rd_en <= 1'b0;
    #1 chk(rdata, exp);
  endtask
  function automatic logic [31:0] cf(input int c, input int d, input int s, input int k);
    return {24'h00_0000, 1'(k), 1'(s), 2'(d), 3'(c), 1'b1};
  endfunction
  task automatic el(input int e, input logic [31:0] c, input logic [15:0] pu,
                    input logic [9:0] m);
    wr(8'h40 + 8'(e * 16), {16'h0000, pu});
    wr(8'h44 + 8'(e * 16), c);
    wr(8'h48 + 8'(e * 16), {22'h00_0000, m});
  endtask
  task automatic lv(input int e, input logic [15:0] v, input logic x);
    @(posedge clk);
    fe.cur[e] <= v;
    repeat (3) @(posedge clk);
    #1 chk(pickup[e], x);
  endtask
  task automatic drv(input logic inh, input logic byp);
    @(posedge clk);
    trip_inhibit <= {5'h00, inh};
    delay_bypass <= {5'h00, byp};
    repeat (3) @(posedge clk);
    #1;
  endtask
  function automatic real ems(input int c, input real is, input real m);
    real t;
    case (c)
      1: t = 13.5 / (is - 1.0);
      2: t = 120.0 / (is - 1.0);
      3: t = 0.114 + 0.0515 / ($pow(is, 0.02) - 1.0);
      4: t = 0.1217 + 28.2 / (is * is - 1.0);
      5: t = 0.0352 + 5.67 / (is * is - 1.0);
      default: t = 0.05;
    endcase
    if (c < 3 && m > 1.0) m = 1.0;
    return t * m * 1000.0;
  endfunction
  // Tick phase is unknown, so allow a couple of ticks on top of 5 percent
  task automatic tm(input int e, input logic [15:0] v, input int pre, input real ms);
    int n;
    n = 0;
    if (pre > 0) begin
      lv(e, v, 1'b1);
      repeat (pre * SC) @(posedge clk);
      lv(e, 16'h0000, 1'b0);
    end
    @(posedge clk);
    fe.cur[e] <= v;
    while (trip[e] !== 1'b1 && n < 30000) begin
      @(posedge clk);
      #1 n++;
    end
    chk(n >= 0.95 * ms * SC - 2 * SC && n <= 1.05 * ms * SC + 2 * SC, 1'b1);
    lv(e, 16'h0000, 1'b0);
  endtask
  initial begin
    int e, d, s, u, eff, hi, lo, p;
    logic x, r;
    logic [5:0][15:0] vv;
    int pt[9] = '{100, 90, 89, 75, 50, 26, 25, 10, 0};
    int vc[6] = '{600, 500, 524, 525, 501, 500};
    logic [5:0] vx = 6'h26;
    int tc[6] = '{1, 2, 3, 4, 0, 5};
    logic [9:0] tmu[6] = '{10'h0C8, 10'h005, 10'h00A, 10'h00A, 10'h064, 10'h00A};
    logic [15:0] tcu[6] = '{16'h9C40, 16'h9C40, 16'h2710, 16'h2710, 16'h07D0, 16'h2710};
    void'($urandom(60));
    repeat (20) @(posedge clk);
    reset <= 1'b0;
    rd(8'h48, 32'h0000_0064);
    rd(8'h4C, 32'h0000_01F4);
    rd(8'h04, 32'h0000_0064);
    wr(8'h20, 32'hFFFF_FFFF);
    rd(8'h20, 32'h0000_0000);
    for (int i = 0; i < 6; i++) el(i, cf(0, 0, 0, 0), 16'h03E8, 10'h064);
    lv(1, 16'h0419, 1'b0);
    lv(1, 16'h041A, 1'b1);
    lv(1, 16'h03E9, 1'b1);
    lv(1, 16'h03E8, 1'b0);
    for (int i = 0; i < 12; i++) begin
      e = i % 3 == 0 ? 0 : i % 3 == 1 ? 3 : 5;
      d = $urandom % 3;
      s = $urandom % 2;
      u = e == 0 ? 0 : (e == 5 || s == 1) ? 4 : 3;
      @(posedge clk);
      fe.fwd <= 5'($urandom);
      fe.rev <= 5'($urandom);
      wr(8'h44 + 8'(e * 16), cf(0, d, s, 0));
      x = d == 0 ? 1'b1 : d == 1 ? fe.fwd[u] : fe.rev[u];
      lv(e, 16'h07D0, x);
      lv(e, 16'h0000, 1'b0);
    end
    wr(8'h44, cf(0, 0, 0, 0));
    drv(1'b1, 1'b1);
    lv(0, 16'h07D0, 1'b1);
    chk(trip[0], 1'b0);
    drv(1'b0, 1'b1);
    chk(trip[0], 1'b1);
    drv(1'b1, 1'b1);
    chk(trip[0], 1'b0);
    drv(1'b0, 1'b0);
    lv(0, 16'h0000, 1'b0);
    for (int i = 0; i < 6; i++) begin
      el(i, cf(tc[i], 0, 0, 0), 16'h03E8, tmu[i]);
      tm(i, tcu[i], 0, ems(tc[i], tcu[i] / 1000.0, tmu[i] / 100.0));
    end
    tm(3, 16'h2710, 20, ems(4, 10.0, 0.1));
    wr(8'h74, cf(4, 0, 0, 1));
    tm(3, 16'h2710, 20, ems(4, 10.0, 0.1) - 20.0);
    wr(8'h84, cf(6, 0, 0, 1));
    tm(4, 16'h07D0, 20, 50.0);
    wr(8'h04, 32'h0000_03E8);
    for (int i = 0; i < 12; i++) begin
      e = $urandom % 3;
      r = 1'($urandom);
      p = i < 9 ? pt[i] : $urandom % 111;
      eff = p >= 90 ? 2000 : p <= 25 ? 500 : 20 * p;
      hi = (eff * 105 + 99) / 100 + 2;
      lo = eff * 105 / 100 - 2;
      wr(8'h00, {29'h0000_0000, r, 2'b01});
      wr(8'h40 + 8'(e * 16), 32'h0000_07D0);
      vv = {6{16'h03E8}};
      vv[r ? e + 3 : e] = 16'(p * 10);
      @(posedge clk);
      fe.volt <= vv;
      lv(e, 16'(lo), 1'b0);
      lv(e, 16'(hi), 1'b1);
      lv(e, 16'h0000, 1'b0);
    end
    wr(8'h00, 32'h0000_0002);
    wr(8'h08, 32'h0000_01F4);
    wr(8'h40, 32'h0000_03E8);
    @(posedge clk);
    fe.volt <= {6{16'h03E8}};
    fe.cur[0] <= 16'h07D0;
    for (int i = 0; i < 6; i++) begin
      @(posedge clk);
      fe.volt[0] <= 16'(vc[i]);
      repeat (4) @(posedge clk);
      #1 chk(pickup[0], vx[i]);
    end
    rd(8'h0C, 32'h0001_0001);
    wr(8'h0C, 32'hFFFF_FFFF);
    rd(8'h0C, 32'h0001_0001);
    conclude();
  end
endmodule
